// ==== common/rtcal_pkg.sv ====
package rtcal_pkg;

   // Clock and prescale figures
   localparam int unsigned REF_CLK_HZ    = 100_000_000;
   localparam int unsigned XTAL_HZ       = 32_768;
   localparam int unsigned TICK_HZ       = 1;
   localparam int unsigned PRESCALE_DIV  = XTAL_HZ / TICK_HZ;
   localparam int unsigned PRESCALE_W    = 15;
   localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_W'(PRESCALE_DIV - 1);
   localparam logic [PRESCALE_W-1:0] PRESCALE_HALF = PRESCALE_W'(PRESCALE_DIV / 2 - 1);

   // Counter spans
   localparam logic [5:0]  SEC_LAST  = 6'h3B;
   localparam logic [5:0]  MIN_LAST  = 6'h3B;
   localparam logic [4:0]  HOUR_LAST = 5'h17;
   localparam logic [14:0] DAY_LAST  = 15'h7FFF;

   // Interrupt source indices
   localparam int unsigned IRQ_N      = 7;
   localparam int unsigned IRQ_SEC    = 0;
   localparam int unsigned IRQ_MIN    = 1;
   localparam int unsigned IRQ_HOUR   = 2;
   localparam int unsigned IRQ_DAY    = 3;
   localparam int unsigned IRQ_ALARM1 = 4;
   localparam int unsigned IRQ_ALARM2 = 5;
   localparam int unsigned IRQ_SWATCH = 6;

   // Time of day and full time stamp
   typedef struct packed {
      logic [4:0] hours;
      logic [5:0] minutes;
      logic [5:0] seconds;
   } rtcal_tod_t;

   typedef struct packed {
      logic [14:0] days;
      rtcal_tod_t  tod;
   } rtcal_time_t;

   // Stopwatch states
   typedef enum logic [1:0] {
      RTCAL_SW_IDLE = 2'b01,
      RTCAL_SW_RUN  = 2'b10
   } rtcal_sw_state_t;

endpackage

// ==== hw/rtcal_core.sv ====
// Summary of operation
// - The crystal rate is prescaled to a once-per-second tick that alone advances the counters.
// - Seconds and minutes each span sixty values, minutes stepping when seconds wrap.
// - Hours span twenty-four values and days 32768, each stepping when the lower one wraps.
// - An enabled alarm raises its interrupt once the running time equals its programmed value.
// - The first alarm matches hours, minutes and seconds only, on any day.
// - The second alarm matches day, hours, minutes and seconds together.
// - The stopwatch loads a programmed value and decrements by one on each second tick.
// - An enabled stopwatch raises its interrupt on the tick where it underflows.
// - Separately enabled periodic interrupts fire per second, minute, hour and day rollover.
// - A calibration output toggles twice per second from the prescaler, giving a one hertz square wave.
// - Time keeping runs on its own always-on domain, unaffected by core low power.
module rtcal_core
   import rtcal_pkg::*;
(
   // Always-on clock and reset
   input  wire logic              ref_clk,
   input  wire logic              arst_n,
   // Crystal rate enable, one cycle per crystal period
   input  wire logic              xtal_tick,
   // Time set
   input  wire logic              time_load,
   input  wire rtcal_time_t       time_load_value,
   // Alarm programming
   input  wire rtcal_tod_t        alarm1_value,
   input  wire rtcal_time_t       alarm2_value,
   // Stopwatch control
   input  wire logic              swatch_load,
   input  wire logic [15:0]       swatch_load_value,
   // Interrupt enables and clears, one bit per source
   input  wire logic [IRQ_N-1:0]  irq_enable,
   input  wire logic [IRQ_N-1:0]  irq_clear,
   // Status and outputs
   output rtcal_time_t            time_now,
   output logic [15:0]            swatch_count,
   output logic                   swatch_running,
   output logic [IRQ_N-1:0]       irq_flags,
   output logic [IRQ_N-1:0]       irq_out,
   output logic                   calibration_tick_out
);

   logic            sec_tick;
   logic            half_wave;
   rtcal_time_t     next_time;
   logic            sec_wrap;
   logic            min_wrap;
   logic            hour_wrap;
   logic            day_wrap;
   logic [IRQ_N-1:0] events;
   logic [IRQ_N-1:0] next_flags;
   logic [IRQ_N-1:0] next_irq_out;
   rtcal_sw_state_t sw_state;
   rtcal_sw_state_t next_sw_state;
   logic [15:0]     next_swatch;
   logic            sw_underflow;

   // Prescaler on the always-on clock
   rtcal_prescaler u_prescaler (
      .ref_clk   (ref_clk),
      .arst_n    (arst_n),
      .xtal_tick (xtal_tick),
      .sec_tick  (sec_tick),
      .half_wave (half_wave)
   );

   // Equality of a time of day
   function automatic logic tod_match(input rtcal_tod_t a, input rtcal_tod_t b);
      tod_match = (a == b);
   endfunction

   // Cascaded counters
   always_comb begin
      next_time = time_now;
      sec_wrap  = sec_tick && (time_now.tod.seconds == SEC_LAST);
      min_wrap  = sec_wrap && (time_now.tod.minutes == MIN_LAST);
      hour_wrap = min_wrap && (time_now.tod.hours == HOUR_LAST);
      day_wrap  = hour_wrap && (time_now.days == DAY_LAST);
      if (time_load) begin
         next_time = time_load_value;
      end else if (sec_tick) begin
         next_time.tod.seconds = sec_wrap ? '0 : time_now.tod.seconds + 1'b1;
         if (sec_wrap) begin
            next_time.tod.minutes = min_wrap ? '0 : time_now.tod.minutes + 1'b1;
         end
         if (min_wrap) begin
            next_time.tod.hours = hour_wrap ? '0 : time_now.tod.hours + 1'b1;
         end
         if (hour_wrap) begin
            next_time.days = day_wrap ? '0 : time_now.days + 1'b1;
         end
      end
   end

   // Stopwatch next state
   always_comb begin
      next_sw_state = sw_state;
      next_swatch   = swatch_count;
      sw_underflow  = 1'b0;
      case (sw_state)
         RTCAL_SW_IDLE: begin
            if (swatch_load) begin
               next_swatch   = swatch_load_value;
               next_sw_state = RTCAL_SW_RUN;
            end
         end
         RTCAL_SW_RUN: begin
            if (swatch_load) begin
               next_swatch = swatch_load_value;
            end else if (sec_tick) begin
               next_swatch = swatch_count - 1'b1;
               if (swatch_count == '0) begin
                  sw_underflow  = 1'b1;
                  next_sw_state = RTCAL_SW_IDLE;
               end
            end
         end
         default: begin
            next_sw_state = RTCAL_SW_IDLE;
         end
      endcase
   end

   // Event sources and sticky flags
   always_comb begin
      events             = '0;
      events[IRQ_SEC]    = sec_tick;
      events[IRQ_MIN]    = sec_wrap;
      events[IRQ_HOUR]   = min_wrap;
      events[IRQ_DAY]    = hour_wrap;
      events[IRQ_ALARM1] = !time_load && !tod_match(time_now.tod, next_time.tod)
                           && tod_match(next_time.tod, alarm1_value);
      events[IRQ_ALARM2] = !time_load && (time_now != next_time)
                           && (next_time == alarm2_value);
      events[IRQ_SWATCH] = sw_underflow;
      // Set wins over clear
      next_flags   = (irq_flags & ~irq_clear) | events;
      next_irq_out = next_flags & irq_enable;
   end

   // Registered state
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         time_now             <= '0;
         sw_state             <= RTCAL_SW_IDLE;
         swatch_count         <= '0;
         swatch_running       <= 1'b0;
         irq_flags            <= '0;
         irq_out              <= '0;
         calibration_tick_out <= 1'b0;
      end else begin
         time_now             <= next_time;
         sw_state             <= next_sw_state;
         swatch_count         <= next_swatch;
         swatch_running       <= (next_sw_state == RTCAL_SW_RUN);
         irq_flags            <= next_flags;
         irq_out              <= next_irq_out;
         calibration_tick_out <= half_wave;
      end
   end

   // Checks
   a_sec_step: assert property (@(posedge ref_clk) disable iff (!arst_n)
      !sec_tick && !time_load |=> $stable(time_now))
      else $error("time moved without a second tick");
   a_sec_wrap: assert property (@(posedge ref_clk) disable iff (!arst_n)
      sec_tick && !time_load && time_now.tod.seconds == SEC_LAST |=>
      time_now.tod.seconds == '0 && time_now.tod.minutes != $past(time_now.tod.minutes))
      else $error("seconds wrap did not step minutes");
   a_hour_wrap: assert property (@(posedge ref_clk) disable iff (!arst_n)
      sec_tick && !time_load && time_now.tod == rtcal_tod_t'{HOUR_LAST, MIN_LAST, SEC_LAST}
      |=> time_now.tod == '0 && time_now.days == $past(time_now.days) + 1'b1)
      else $error("day did not step on hour wrap");
   a_alarm1_hit: assert property (@(posedge ref_clk) disable iff (!arst_n)
      events[IRQ_ALARM1] && !irq_clear[IRQ_ALARM1]
      |=> irq_flags[IRQ_ALARM1] && time_now.tod == alarm1_value)
      else $error("alarm one flag missing");
   a_alarm2_hit: assert property (@(posedge ref_clk) disable iff (!arst_n)
      $rose(irq_flags[IRQ_ALARM2]) |-> time_now == $past(alarm2_value))
      else $error("alarm two set without full match");
   a_sw_decr: assert property (@(posedge ref_clk) disable iff (!arst_n)
      swatch_running && sec_tick && !swatch_load |=> swatch_count == $past(swatch_count) - 1'b1)
      else $error("stopwatch did not decrement");
   a_sw_under: assert property (@(posedge ref_clk) disable iff (!arst_n)
      swatch_running && sec_tick && !swatch_load && swatch_count == '0
      |=> irq_flags[IRQ_SWATCH] && !swatch_running)
      else $error("stopwatch underflow missed");
   a_irq_gate: assert property (@(posedge ref_clk) disable iff (!arst_n)
      irq_out == (irq_flags & $past(irq_enable)))
      else $error("interrupt output not gated by enable");
   a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!arst_n)
      irq_flags[IRQ_SEC] && !irq_clear[IRQ_SEC] |=> irq_flags[IRQ_SEC])
      else $error("flag dropped without clear");
   a_min_irq: assert property (@(posedge ref_clk) disable iff (!arst_n)
      sec_wrap |=> irq_flags[IRQ_MIN])
      else $error("minute flag missing");

   c_min_roll:  cover property (@(posedge ref_clk) disable iff (!arst_n) min_wrap);
   c_alarm1:    cover property (@(posedge ref_clk) disable iff (!arst_n) irq_out[IRQ_ALARM1]);
   c_sw_under:  cover property (@(posedge ref_clk) disable iff (!arst_n) sw_underflow);
   c_set_clear: cover property (@(posedge ref_clk) disable iff (!arst_n)
      events[IRQ_SEC] && irq_clear[IRQ_SEC]);

endmodule

// ==== hw/rtcal_prescaler.sv ====
// Divides the crystal clock to a one-per-second tick and a 1 Hz square wave
module rtcal_prescaler
   import rtcal_pkg::*;
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic arst_n,
   // Crystal enable and outputs
   input  wire logic xtal_tick,
   output logic      sec_tick,
   output logic      half_wave
);

   logic [PRESCALE_W-1:0] count;
   logic [PRESCALE_W-1:0] next_count;
   logic                  next_sec_tick;
   logic                  next_half_wave;

   // Count crystal edges, wrap each second
   always_comb begin
      next_count     = count;
      next_sec_tick  = 1'b0;
      next_half_wave = half_wave;
      if (xtal_tick) begin
         if (count == PRESCALE_LAST) begin
            next_count    = '0;
            next_sec_tick = 1'b1;
         end else begin
            next_count = count + 1'b1;
         end
         if (count == PRESCALE_LAST || count == PRESCALE_HALF) begin
            next_half_wave = ~half_wave;
         end
      end
   end

   // Prescaler state
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         count     <= '0;
         sec_tick  <= 1'b0;
         half_wave <= 1'b0;
      end else begin
         count     <= next_count;
         sec_tick  <= next_sec_tick;
         half_wave <= next_half_wave;
      end
   end

endmodule

// ==== test/rtcal_core_tb.sv ====
module tb
   import rtcal_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // Clock, reset and stimulus
   logic              ref_clk;
   logic              arst_n;
   logic              xtal_tick;
   logic              time_load;
   rtcal_time_t       time_load_value;
   rtcal_tod_t        alarm1_value;
   rtcal_time_t       alarm2_value;
   logic              swatch_load;
   logic [15:0]       swatch_load_value;
   logic [IRQ_N-1:0]  irq_enable;
   logic [IRQ_N-1:0]  irq_clear;
   // Observed outputs
   rtcal_time_t       time_now;
   logic [15:0]       swatch_count;
   logic              swatch_running;
   logic [IRQ_N-1:0]  irq_flags;
   logic [IRQ_N-1:0]  irq_out;
   logic              calibration_tick_out;
   // Bookkeeping
   int                n_fail;
   int                checks_done;
   int                tg;
   rtcal_time_t       exp_q[$];
   rtcal_time_t       last_time;
   logic [7:0]        seed;

   rtcal_core DUT (.ref_clk(ref_clk), .arst_n(arst_n), .xtal_tick(xtal_tick),
      .time_load(time_load), .time_load_value(time_load_value),
      .alarm1_value(alarm1_value), .alarm2_value(alarm2_value),
      .swatch_load(swatch_load), .swatch_load_value(swatch_load_value),
      .irq_enable(irq_enable), .irq_clear(irq_clear), .time_now(time_now),
      .swatch_count(swatch_count), .swatch_running(swatch_running),
      .irq_flags(irq_flags), .irq_out(irq_out),
      .calibration_tick_out(calibration_tick_out));

   // Compare one value and count it
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Counts, verdict and end of run
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Pseudo-random source
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // Wait for the next counter step, counting calibration toggles
   task automatic wait_tick(output int toggles);
      logic        c;
      rtcal_time_t t0;
      int          i;
      t0 = time_now;
      c = calibration_tick_out;
      toggles = 0;
      for (i = 0; i < 40000 && time_now === t0; i++) begin
         @(negedge ref_clk);
         if (calibration_tick_out !== c) begin
            toggles++;
            c = calibration_tick_out;
         end
      end
      if (time_now === t0) begin
         check("tick_wait", 1, 0);
         conclude();
      end
   endtask

   // Free-running clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Hang guard
   initial begin
      repeat (90000) @(posedge ref_clk);
      check("timeout", 1, 0);
      conclude();
   end

   // Watcher: each change of time takes the oldest note
   initial last_time = '0;
   always @(posedge ref_clk) begin
      #1;
      if (arst_n && time_now !== last_time) begin
         if (exp_q.size() == 0) begin
            check("time_unexpected", time_now, last_time);
         end else begin
            check("time_now", time_now, exp_q.pop_front());
         end
         last_time = time_now;
      end
   end

   // Main sequence
   initial begin
      n_fail = 0;
      checks_done = 0;
      seed = 8'h17;
      arst_n = 1'b0;
      xtal_tick = 1'b0;
      time_load = 1'b0;
      time_load_value = '0;
      alarm1_value = '0;
      alarm2_value = '0;
      swatch_load = 1'b0;
      swatch_load_value = '0;
      irq_enable = '0;
      irq_clear = '0;
      repeat (3) @(negedge ref_clk);
      arst_n = 1'b1;
      check("reset_time", time_now, 0);
      check("reset_flags", irq_flags, 0);
      check("reset_swatch", {swatch_running, swatch_count}, 0);
      xtal_tick = 1'b1;
      @(negedge ref_clk);
      // Last day, two seconds before midnight
      time_load = 1'b1;
      time_load_value = {15'h7FFF, 5'h17, 6'h3B, 6'h3A};
      exp_q.push_back(time_load_value);
      exp_q.push_back({15'h7FFF, 5'h17, 6'h3B, 6'h3B});
      exp_q.push_back('0);
      alarm1_value = {5'h17, 6'h3B, 6'h3B};
      alarm2_value = '0;
      irq_enable = '1;
      swatch_load = 1'b1;
      swatch_load_value = 16'h0001;
      @(negedge ref_clk);
      time_load = 1'b0;
      swatch_load = 1'b0;
      check("swatch_loaded", {swatch_running, swatch_count}, 17'h10001);
      wait_tick(tg);
      check("flags_t1", irq_flags, 7'h11);
      check("irq_t1", irq_out, 7'h11);
      check("swatch_t1", swatch_count, 16'h0000);
      irq_clear = '1;
      @(negedge ref_clk);
      irq_clear = '0;
      check("flags_clr", irq_flags, 0);
      wait_tick(tg);
      check("cal_toggles", tg, 2);
      check("flags_t2", irq_flags, 7'h6F);
      check("swatch_t2", {swatch_running, swatch_count}, 17'h0FFFF);
      // Random enable masks gate the outputs
      repeat (4) begin
         seed = lfsr(seed);
         irq_enable = seed[6:0];
         @(negedge ref_clk);
         check("irq_mask", irq_out, 7'h6F & seed[6:0]);
      end
      irq_clear = seed[6:0];
      @(negedge ref_clk);
      irq_clear = '0;
      @(negedge ref_clk);
      check("flags_part", irq_flags, 7'h6F & ~seed[6:0]);
      check("queue_left", exp_q.size(), 0);
      conclude();
   end
endmodule
